// ### src/dpv1c1_pkg.sv
// shared constants and carrier types for the class 1 acyclic request handler
package dpv1c1_pkg;
   localparam logic [7:0] SVC_READ = 8'h52;
   localparam logic [7:0] SVC_WRITE = 8'h53;
   localparam logic [7:0] OBJ_CLASS = 8'h64;
   localparam logic [7:0] OBJ_INST = 8'h01;
   // request payload byte positions, timeout is little endian in 0..3
   localparam logic [8:0] POS_STATION = 9'h004;
   localparam logic [8:0] POS_SLOT = 9'h005;
   localparam logic [8:0] POS_INDEX = 9'h006;
   localparam logic [8:0] POS_LEN = 9'h007;
   localparam logic [8:0] REQ_HDR_LEN = 9'h008;
   localparam logic [8:0] RSP_RD_HDR = 9'h006;
   localparam logic [8:0] RSP_WR_LEN = 9'h005;
   localparam logic [7:0] MAX_STATION = 8'h7e;
   // exchange status codes produced locally
   localparam logic [7:0] DP_ST_NOT_DX = 8'h81;
   localparam logic [7:0] DP_ST_TIMEOUT = 8'h82;
   // explicit message general status
   localparam logic [7:0] CIP_OK = 8'h00;
   localparam logic [7:0] CIP_BAD_PATH = 8'h05;
   localparam logic [7:0] CIP_BAD_SVC = 8'h08;
   localparam logic [7:0] CIP_BAD_LEN = 8'h13;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [7:0] service;
      logic [7:0] cls;
      logic [7:0] inst;
      logic attr_present;
      logic [15:0] length;
   } dpv1c1_hdr_s;

   typedef struct packed {
      logic wr;
      logic [7:0] station;
      logic [7:0] slot;
      logic [7:0] index;
      logic [7:0] len;
   } dpv1c1_cmd_s;

   typedef struct packed {
      logic [7:0] status;
      logic [23:0] ext;
      logic [7:0] len;
   } dpv1c1_res_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CHECK = 3'b001,
      ST_FB = 3'b010,
      ST_RSP = 3'b011,
      ST_DONE = 3'b100
   } dpv1c1_state_e;
endpackage

// ### src/dpv1c1_ms_timer.sv
// millisecond response timeout counter
`timescale 1ns/1ps
`default_nettype none
module dpv1c1_ms_timer #(
   parameter int unsigned CYC_PER_MS = dpv1c1_pkg::CYC_PER_MS
) (
   input wire logic mclk, // system clock
   input wire logic rst_n, // sync reset
   input wire logic load, // start timing ms
   input wire logic stop, // halt and clear
   input wire logic [31:0] ms, // timeout in ms
   output logic expired // level until next load or stop
);
   logic [31:0] pre_r;
   logic [31:0] left_r;
   logic run_r;
   logic tick_w;

   assign tick_w = run_r && (pre_r == 32'(CYC_PER_MS - 1));

   always_ff @(posedge mclk) begin
      if (!rst_n || load || !run_r || tick_w) begin
         pre_r <= 32'h0000_0000;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || stop) begin
         run_r <= 1'b0;
         left_r <= 32'h0000_0000;
         expired <= 1'b0;
      end else if (load) begin
         run_r <= 1'b1;
         left_r <= ms;
         expired <= 1'b0;
      end else if (run_r && left_r == 32'h0000_0000) begin
         run_r <= 1'b0;
         expired <= 1'b1;
      end else if (tick_w) begin
         left_r <= left_r - 32'h0000_0001;
      end
   end
endmodule
`default_nettype wire

// ### src/dpv1c1_handler.sv
// class 1 acyclic read/write request handler
`timescale 1ns/1ps
`default_nettype none
// How it works
// - act only when the station is configured and in cyclic data exchange
// - act only on stations whose cyclic exchange this master owns
// - read is service 0x52, class 0x64, instance 1, no attribute, 8 bytes
// - requests start with a ms timeout; expiry answers with timeout status
// - read answer: status, 3 extended status, length, reserved, data
// - read answer carries exactly as many data bytes as its length field
// - write is service 0x53, class 0x64, instance 1, no attribute
// - write answer: status, 3 extended status, bytes written
module dpv1c1_handler #(
   parameter int unsigned CYC_PER_MS = dpv1c1_pkg::CYC_PER_MS
) (
   input wire logic mclk, // 10 MHz clock
   input wire logic rst_n, // sync reset
   input wire dpv1c1_pkg::dpv1c1_hdr_s req_hdr, // message header, held during payload
   input wire logic req_valid, // payload byte valid
   input wire logic [7:0] req_data, // payload byte
   input wire logic req_last, // final payload byte
   output logic req_ready, // payload byte taken
   output logic rsp_valid, // answer byte valid
   output logic [7:0] rsp_data, // answer byte
   output logic rsp_last, // final answer byte
   input wire logic rsp_ready, // answer byte taken
   output logic rsp_done, // answer complete pulse
   output logic [7:0] rsp_cip_status, // general status of answer
   input wire logic [127:0] dx_map, // station configured and exchanging
   input wire logic [127:0] own_map, // exchange run by this master
   output logic fb_start, // fieldbus job pulse
   output dpv1c1_pkg::dpv1c1_cmd_s fb_cmd, // fieldbus job
   output logic fb_abort, // job dropped on timeout
   input wire logic fb_done, // fieldbus result pulse
   input wire dpv1c1_pkg::dpv1c1_res_s fb_res, // fieldbus result
   input wire logic fb_rd_we, // read data store strobe
   input wire logic [7:0] fb_rd_addr, // read data position
   input wire logic [7:0] fb_rd_data, // read data byte
   input wire logic [7:0] fb_wr_addr, // write data position
   output logic [7:0] fb_wr_data // write data, one cycle later
);
   dpv1c1_pkg::dpv1c1_state_e st_r;
   dpv1c1_pkg::dpv1c1_hdr_s hdr_r;
   dpv1c1_pkg::dpv1c1_res_s res_r;
   logic [7:0] buf_r [0:255];
   logic [31:0] tmo_r;
   logic [7:0] sta_r;
   logic [7:0] slot_r;
   logic [7:0] idx_r;
   logic [7:0] len_r;
   logic [8:0] cnt_r;
   logic [8:0] ridx_r;
   logic [8:0] tot_w;
   logic [8:0] nb_r;
   logic take_w;
   logic is_wr_w;
   logic hdr_ok_w;
   logic svc_ok_w;
   logic len_ok_w;
   logic dx_ok_w;
   logic own_ok_w;
   logic tmo_w;
   logic tmo_load_w;
   logic [7:0] rd_len_w;

   function automatic logic station_bit(input logic [127:0] map, input logic [7:0] sta);
      station_bit = (sta <= dpv1c1_pkg::MAX_STATION) ? map[sta[6:0]] : 1'b0;
   endfunction

   assign take_w = req_valid && req_ready;
   assign is_wr_w = (hdr_r.service == dpv1c1_pkg::SVC_WRITE);
   assign svc_ok_w = (hdr_r.service == dpv1c1_pkg::SVC_READ) || is_wr_w;
   assign hdr_ok_w = hdr_r.cls == dpv1c1_pkg::OBJ_CLASS && hdr_r.inst == dpv1c1_pkg::OBJ_INST
      && !hdr_r.attr_present;
   assign len_ok_w = is_wr_w ? (cnt_r == dpv1c1_pkg::REQ_HDR_LEN + {1'b0, len_r}
      && hdr_r.length == {7'h00, cnt_r})
      : (cnt_r == dpv1c1_pkg::REQ_HDR_LEN && hdr_r.length == 16'h0008);
   assign dx_ok_w = station_bit(dx_map, sta_r);
   assign own_ok_w = station_bit(own_map, sta_r);
   assign tmo_load_w = (st_r == dpv1c1_pkg::ST_CHECK) && svc_ok_w && hdr_ok_w && len_ok_w
      && dx_ok_w && own_ok_w;
   assign rd_len_w = (fb_res.len > len_r) ? len_r : fb_res.len;
   assign tot_w = (rsp_cip_status != dpv1c1_pkg::CIP_OK) ? 9'h000
      : is_wr_w ? dpv1c1_pkg::RSP_WR_LEN : dpv1c1_pkg::RSP_RD_HDR + {1'b0, res_r.len};

   dpv1c1_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmo (
      .mclk(mclk),
      .rst_n(rst_n),
      .load(tmo_load_w),
      .stop(st_r != dpv1c1_pkg::ST_FB && !tmo_load_w),
      .ms(tmo_r),
      .expired(tmo_w)
   );

   // request intake, field order fixed by position
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         req_ready <= 1'b1;
         cnt_r <= 9'h000;
         hdr_r <= '0;
         tmo_r <= 32'h0000_0000;
         sta_r <= 8'h00;
         slot_r <= 8'h00;
         idx_r <= 8'h00;
         len_r <= 8'h00;
      end else if (take_w) begin
         if (cnt_r == 9'h000) begin
            hdr_r <= req_hdr;
         end
         if (cnt_r < dpv1c1_pkg::POS_STATION) begin
            tmo_r <= {req_data, tmo_r[31:8]};
         end
         if (cnt_r == dpv1c1_pkg::POS_STATION) sta_r <= req_data;
         if (cnt_r == dpv1c1_pkg::POS_SLOT) slot_r <= req_data;
         if (cnt_r == dpv1c1_pkg::POS_INDEX) idx_r <= req_data;
         if (cnt_r == dpv1c1_pkg::POS_LEN) len_r <= req_data;
         if (cnt_r != 9'h1ff) cnt_r <= cnt_r + 9'h001;
         if (req_last) req_ready <= 1'b0;
      end else if (st_r == dpv1c1_pkg::ST_DONE) begin
         req_ready <= 1'b1;
         cnt_r <= 9'h000;
      end
   end

   // shared data store: write data in, read data from the fieldbus
   always_ff @(posedge mclk) begin
      if (take_w && cnt_r >= dpv1c1_pkg::REQ_HDR_LEN && cnt_r < 9'h108) begin
         buf_r[8'(cnt_r - dpv1c1_pkg::REQ_HDR_LEN)] <= req_data;
      end else if (fb_rd_we && st_r == dpv1c1_pkg::ST_FB) begin
         buf_r[fb_rd_addr] <= fb_rd_data;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fb_wr_data <= 8'h00;
      end else begin
         fb_wr_data <= buf_r[fb_wr_addr];
      end
   end

   // sequencing, checks and fieldbus job
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= dpv1c1_pkg::ST_IDLE;
         res_r <= '0;
         rsp_cip_status <= dpv1c1_pkg::CIP_OK;
         fb_start <= 1'b0;
         fb_abort <= 1'b0;
         fb_cmd <= '0;
      end else begin
         fb_start <= 1'b0;
         fb_abort <= 1'b0;
         case (st_r)
            dpv1c1_pkg::ST_IDLE: begin
               if (take_w && req_last) st_r <= dpv1c1_pkg::ST_CHECK;
            end
            dpv1c1_pkg::ST_CHECK: begin
               res_r <= '0;
               rsp_cip_status <= dpv1c1_pkg::CIP_OK;
               st_r <= dpv1c1_pkg::ST_RSP;
               if (!svc_ok_w) begin
                  rsp_cip_status <= dpv1c1_pkg::CIP_BAD_SVC;
               end else if (!hdr_ok_w) begin
                  rsp_cip_status <= dpv1c1_pkg::CIP_BAD_PATH;
               end else if (!len_ok_w) begin
                  rsp_cip_status <= dpv1c1_pkg::CIP_BAD_LEN;
               end else if (!dx_ok_w || !own_ok_w) begin
                  res_r.status <= dpv1c1_pkg::DP_ST_NOT_DX;
               end else begin
                  fb_start <= 1'b1;
                  fb_cmd <= '{wr: is_wr_w, station: sta_r, slot: slot_r, index: idx_r, len: len_r};
                  st_r <= dpv1c1_pkg::ST_FB;
               end
            end
            dpv1c1_pkg::ST_FB: begin
               if (fb_done) begin
                  res_r <= fb_res;
                  if (!is_wr_w) res_r.len <= rd_len_w;
                  st_r <= dpv1c1_pkg::ST_RSP;
               end else if (tmo_w) begin
                  res_r <= '{status: dpv1c1_pkg::DP_ST_TIMEOUT, ext: 24'h00_0000, len: 8'h00};
                  fb_abort <= 1'b1;
                  st_r <= dpv1c1_pkg::ST_RSP;
               end
            end
            dpv1c1_pkg::ST_RSP: begin
               if (ridx_r == tot_w && (!rsp_valid || rsp_ready)) st_r <= dpv1c1_pkg::ST_DONE;
            end
            dpv1c1_pkg::ST_DONE: begin
               st_r <= dpv1c1_pkg::ST_IDLE;
            end
            default: begin
               st_r <= dpv1c1_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // answer stream
   always_ff @(posedge mclk) begin
      if (!rst_n || st_r != dpv1c1_pkg::ST_RSP) begin
         ridx_r <= 9'h000;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_last <= 1'b0;
      end else if (!rsp_valid || rsp_ready) begin
         if (ridx_r < tot_w) begin
            rsp_valid <= 1'b1;
            rsp_last <= (ridx_r == tot_w - 9'h001);
            ridx_r <= ridx_r + 9'h001;
            case (ridx_r)
               9'h000: rsp_data <= res_r.status;
               9'h001: rsp_data <= res_r.ext[7:0];
               9'h002: rsp_data <= res_r.ext[15:8];
               9'h003: rsp_data <= res_r.ext[23:16];
               9'h004: rsp_data <= res_r.len;
               9'h005: rsp_data <= 8'h00;
               default: rsp_data <= buf_r[8'(ridx_r - dpv1c1_pkg::RSP_RD_HDR)];
            endcase
         end else begin
            rsp_valid <= 1'b0;
            rsp_last <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rsp_done <= 1'b0;
      end else begin
         rsp_done <= (st_r == dpv1c1_pkg::ST_RSP) && ridx_r == tot_w && (!rsp_valid || rsp_ready);
      end
   end

   // answer byte count, checking only
   always_ff @(posedge mclk) begin
      if (!rst_n || st_r == dpv1c1_pkg::ST_CHECK) begin
         nb_r <= 9'h000;
      end else if (rsp_valid && rsp_ready) begin
         nb_r <= nb_r + 9'h001;
      end
   end

   a_dx_gate_start: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_start |-> $past(dx_ok_w)) else $error("job to station not in exchange");
   a_owner_gate_start: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_start |-> $past(own_ok_w)) else $error("job to station owned elsewhere");
   a_read_decode_ok: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_start && !fb_cmd.wr |-> hdr_r.service == dpv1c1_pkg::SVC_READ && hdr_r.cls == dpv1c1_pkg::OBJ_CLASS
      && hdr_r.inst == dpv1c1_pkg::OBJ_INST && !hdr_r.attr_present && cnt_r == dpv1c1_pkg::REQ_HDR_LEN)
      else $error("read job from bad request");
   a_timeout_answer: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r == dpv1c1_pkg::ST_FB && tmo_w && !fb_done |=> fb_abort && st_r == dpv1c1_pkg::ST_RSP
      && res_r.status == dpv1c1_pkg::DP_ST_TIMEOUT) else $error("timeout not answered");
   a_first_byte_status: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(rsp_valid) |-> rsp_data == res_r.status && !(rsp_last && !is_wr_w))
      else $error("answer does not open with status");
   a_read_byte_count: assert property (@(posedge mclk) disable iff (!rst_n)
      rsp_done && !is_wr_w && rsp_cip_status == dpv1c1_pkg::CIP_OK
      |-> nb_r == dpv1c1_pkg::RSP_RD_HDR + {1'b0, res_r.len})
      else $error("read data count differs from length");
   a_write_decode_ok: assert property (@(posedge mclk) disable iff (!rst_n)
      fb_start && fb_cmd.wr |-> hdr_r.service == dpv1c1_pkg::SVC_WRITE && hdr_r.cls == dpv1c1_pkg::OBJ_CLASS
      && !hdr_r.attr_present && hdr_r.length == 16'h0008 + {8'h00, len_r})
      else $error("write job from bad request");
   a_write_answer_len: assert property (@(posedge mclk) disable iff (!rst_n)
      rsp_done && is_wr_w && rsp_cip_status == dpv1c1_pkg::CIP_OK |-> nb_r == dpv1c1_pkg::RSP_WR_LEN)
      else $error("write answer not five bytes");
   a_offline_no_job: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r == dpv1c1_pkg::ST_CHECK && svc_ok_w && hdr_ok_w && len_ok_w && !(dx_ok_w && own_ok_w)
      |=> !fb_start && res_r.status == dpv1c1_pkg::DP_ST_NOT_DX ##1 !fb_start)
      else $error("job issued off exchange");
endmodule
`default_nettype wire

// ### dv/dpv1c1_slave_model.sv
// behavioural fieldbus slave station answering class 1 jobs
`timescale 1ns/1ps
`default_nettype none
module dpv1c1_slave_model (
   input wire logic mclk, // clock
   input wire logic fb_start, // job start
   input wire dpv1c1_pkg::dpv1c1_cmd_s fb_cmd, // job
   input wire logic fb_abort, // job dropped
   input wire logic [7:0] fb_wr_data, // write byte
   input wire logic mute, // never answer
   input wire logic [7:0] ret_len, // bytes a read returns
   input wire logic [31:0] delay, // cycles before answer
   output logic fb_done, // result pulse
   output dpv1c1_pkg::dpv1c1_res_s fb_res, // result
   output logic fb_rd_we, // read store strobe
   output logic [7:0] fb_rd_addr, // read position
   output logic [7:0] fb_rd_data, // read byte
   output logic [7:0] fb_wr_addr, // write position
   output int jobs, // jobs seen
   output int aborts // aborts seen
);
   logic [7:0] got [256];
   dpv1c1_pkg::dpv1c1_cmd_s c;
   initial begin
      aborts = 0;
      forever @(posedge mclk) if (fb_abort) aborts++;
   end
   initial begin
      fb_done = 0; fb_res = '0; fb_rd_we = 0; fb_rd_addr = 0;
      fb_rd_data = 8'h5a; fb_wr_addr = 0; jobs = 0;
      forever begin
         @(posedge mclk);
         if (fb_start) begin
            c = fb_cmd;
            jobs++;
            #1;
            // fetch write bytes, data lags address one cycle
            if (c.wr) for (int i = 0; i <= c.len; i++) begin
               fb_wr_addr = 8'(i);
               @(posedge mclk);
               if (i > 0) got[i-1] = fb_wr_data;
               #1;
            end
            else for (int i = 0; i < ret_len; i++) begin
               fb_rd_we = 1; fb_rd_addr = 8'(i); fb_rd_data = 8'ha0 + 8'(i);
               @(posedge mclk);
               #1;
            end
            fb_rd_we = 0;
            fb_rd_data = ~fb_rd_data;
            repeat (delay) @(posedge mclk);
            #1;
            if (!mute) begin
               fb_done = 1;
               fb_res = '{8'h00, 24'h030201, c.wr ? c.len : ret_len};
               @(posedge mclk);
               #1;
               fb_done = 0;
               fb_res = ~fb_res;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the class 1 acyclic request handler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk = 0, rst_n = 0, req_valid = 0, req_last = 0, rsp_ready = 1, mute = 0, bp = 0, attr = 0;
   logic [7:0] req_data = 0, ret_len = 0, cst;
   dpv1c1_pkg::dpv1c1_hdr_s req_hdr = '0;
   logic [127:0] dx_map = '0, own_map = '0;
   logic req_ready, rsp_valid, rsp_last, rsp_done, fb_start, fb_abort, fb_done, fb_rd_we;
   logic [7:0] rsp_data, rsp_cip_status, fb_rd_addr, fb_rd_data, fb_wr_addr, fb_wr_data;
   dpv1c1_pkg::dpv1c1_cmd_s fb_cmd;
   dpv1c1_pkg::dpv1c1_res_s fb_res;
   int delay = 5, jobs, aborts, num_errors = 0, n_checks = 0, j0;
   logic [7:0] pl[$], ans[$], exp_q[$];
   logic lq[$];
   always #50 mclk = ~mclk;
   dpv1c1_handler #(.CYC_PER_MS(20)) dpv1c1_handler_i (.mclk(mclk), .rst_n(rst_n), .req_hdr(req_hdr),
      .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
      .rsp_done(rsp_done), .rsp_cip_status(rsp_cip_status), .dx_map(dx_map), .own_map(own_map),
      .fb_start(fb_start), .fb_cmd(fb_cmd), .fb_abort(fb_abort), .fb_done(fb_done), .fb_res(fb_res),
      .fb_rd_we(fb_rd_we), .fb_rd_addr(fb_rd_addr), .fb_rd_data(fb_rd_data),
      .fb_wr_addr(fb_wr_addr), .fb_wr_data(fb_wr_data));
   dpv1c1_slave_model dpv1c1_slave_model_i (.mclk(mclk), .fb_start(fb_start), .fb_cmd(fb_cmd),
      .fb_abort(fb_abort), .fb_wr_data(fb_wr_data), .mute(mute), .ret_len(ret_len), .delay(delay),
      .fb_done(fb_done), .fb_res(fb_res), .fb_rd_we(fb_rd_we), .fb_rd_addr(fb_rd_addr),
      .fb_rd_data(fb_rd_data), .fb_wr_addr(fb_wr_addr), .jobs(jobs), .aborts(aborts));
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic hdr(input logic [31:0] to, input logic [7:0] st, input logic [7:0] ln);
      pl = {to[7:0], to[15:8], to[23:16], to[31:24], st, 8'h02, 8'h09, ln};
   endtask
   task automatic run(input logic [7:0] svc, input logic [7:0] cls, input logic [15:0] hl);
      int k;
      ans = {};
      lq = {};
      j0 = jobs;
      req_hdr = '{svc, cls, dpv1c1_pkg::OBJ_INST, attr, hl};
      foreach (pl[i]) begin
         req_valid = 1; req_data = pl[i]; req_last = (i == pl.size() - 1);
         do @(negedge mclk); while (req_ready !== 1'b1);
         @(posedge mclk);
         #1;
      end
      req_valid = 0; req_last = 0;
      for (k = 0; k < 3000 && rsp_done !== 1'b1; k++) begin
         @(negedge mclk);
         if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            ans.push_back(rsp_data);
            lq.push_back(rsp_last);
         end
         @(posedge mclk);
         #1;
         // when bp is set, drop ready every other cycle and hold it low once done
         rsp_ready = !bp || (!rsp_ready && rsp_done !== 1'b1);
      end
      chk(40'(rsp_done), 40'h1);
      cst = rsp_cip_status;
      @(posedge mclk);
      #1;
   endtask
   task automatic cmp_ans();
      chk(40'(ans.size()), 40'(exp_q.size()));
      foreach (exp_q[i]) chk(40'(ans[i]), 40'(exp_q[i]));
      foreach (exp_q[i]) chk(40'(lq[i]), 40'(i == exp_q.size() - 1));
   endtask
   task automatic t_read();
      dx_map[3] = 1; own_map[3] = 1; ret_len = 8'h06;
      hdr(32'd100, 8'h03, 8'h04);
      run(dpv1c1_pkg::SVC_READ, dpv1c1_pkg::OBJ_CLASS, 16'h0008);
      chk(40'(cst), 40'h0);
      chk(40'(fb_cmd), {1'b0, 8'h03, 8'h02, 8'h09, 8'h04});
      chk(40'(jobs), 40'(j0 + 1));
      exp_q = {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'ha0, 8'ha1, 8'ha2, 8'ha3};
      cmp_ans();
      $display("test read done");
   endtask
   task automatic t_write();
      hdr(32'd100, 8'h03, 8'h03);
      pl.push_back(8'h11); pl.push_back(8'h22); pl.push_back(8'h33);
      bp = 1;
      run(dpv1c1_pkg::SVC_WRITE, dpv1c1_pkg::OBJ_CLASS, 16'h000b);
      bp = 0;
      chk(40'(cst), 40'h0);
      chk(40'(fb_cmd), {1'b1, 8'h03, 8'h02, 8'h09, 8'h03});
      for (int i = 0; i < 3; i++) chk(40'(dpv1c1_slave_model_i.got[i]), 40'(pl[8+i]));
      exp_q = {8'h00, 8'h01, 8'h02, 8'h03, 8'h03};
      cmp_ans();
      $display("test write done");
   endtask
   task automatic t_notdx();
      // m=2: station number beyond the bus range, map bits set
      for (int m = 0; m < 3; m++) begin
         dx_map[5] = (m != 0); own_map[5] = (m != 1);
         hdr(32'd100, (m == 2) ? 8'h85 : 8'h05, 8'h04);
         run(dpv1c1_pkg::SVC_READ, dpv1c1_pkg::OBJ_CLASS, 16'h0008);
         chk(40'(jobs), 40'(j0));
         exp_q = {dpv1c1_pkg::DP_ST_NOT_DX, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
         cmp_ans();
      end
      $display("test not in exchange done");
   endtask
   task automatic t_timeout();
      int a0;
      a0 = aborts;
      mute = 1;
      hdr(32'd1, 8'h03, 8'h04);
      run(dpv1c1_pkg::SVC_READ, dpv1c1_pkg::OBJ_CLASS, 16'h0008);
      chk(40'(ans[0]), 40'(dpv1c1_pkg::DP_ST_TIMEOUT));
      chk(40'(aborts), 40'(a0 + 1));
      exp_q = {dpv1c1_pkg::DP_ST_TIMEOUT, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      cmp_ans();
      mute = 0;
      $display("test timeout done");
   endtask
   task automatic t_bad();
      logic [7:0] sv[5] = '{8'h56, 8'h52, 8'h53, 8'h52, 8'h52};
      logic [7:0] cl[5] = '{8'h64, 8'h65, 8'h64, 8'h64, 8'h64};
      logic [7:0] es[5] = '{8'h08, 8'h05, 8'h13, 8'h13, 8'h05};
      for (int i = 0; i < 5; i++) begin
         hdr(32'd100, 8'h03, 8'h02);
         if (i == 3) pl.push_back(8'h00);
         attr = (i == 4);
         run(sv[i], cl[i], 16'(pl.size()));
         chk(40'(cst), 40'(es[i]));
         chk(40'(ans.size()), 40'h0);
         chk(40'(jobs), 40'(j0));
      end
      attr = 0;
      $display("test bad request done");
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #(30000 * 100);
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (20) @(posedge mclk);
      #1;
      rst_n = 1;
      t_read();
      t_write();
      t_notdx();
      t_timeout();
      t_bad();
      end_sim();
   end
endmodule
`default_nettype wire
